// file: design/mwt_axis_cmp.sv
// per-axis magnitude comparator for the motion-warning detector
`timescale 1ns/1ns
`default_nettype none
module mwt_axis_cmp (
  input  wire logic signed [mwt_pkg::SAMPLE_W-1:0] sample,   // new signed sample
  input  wire logic signed [mwt_pkg::SAMPLE_W-1:0] refSample, // captured reference
  input  wire logic                                useRef,   // referenced processing
  input  wire logic        [mwt_pkg::LEVEL_W-1:0]  level,    // unsigned threshold
  input  wire logic                                enable,   // axis participates
  output logic                                     over      // enabled and above level
);
  logic signed [mwt_pkg::SAMPLE_W:0] diff;
  logic        [mwt_pkg::MAG_W-1:0]  mag;

  // 13-bit difference so a full-scale swing against the reference cannot wrap
  always_comb begin
    if (useRef) begin
      diff = 13'(sample) - 13'(refSample);
    end else begin
      diff = 13'(sample);
    end
    if (diff[mwt_pkg::SAMPLE_W]) begin
      mag = mwt_pkg::MAG_W'(-diff);
    end else begin
      mag = mwt_pkg::MAG_W'(diff);
    end
    over = enable && (mag > {1'b0, level});
  end
endmodule // mwt_axis_cmp
`default_nettype wire

// file: design/mwt_pkg.sv
// constants for the motion-warning threshold and high-pass corner registers
package mwt_pkg;
  // register addresses
  localparam logic [7:0] ADDR_AXIS_BASE = 8'h32; // x high byte, then low, y high, ...
  localparam logic [7:0] ADDR_X_HIGH    = 8'h32;
  localparam logic [7:0] ADDR_X_LOW     = 8'h33;
  localparam logic [7:0] ADDR_Y_HIGH    = 8'h34;
  localparam logic [7:0] ADDR_Y_LOW     = 8'h35;
  localparam logic [7:0] ADDR_Z_HIGH    = 8'h36;
  localparam logic [7:0] ADDR_Z_LOW     = 8'h37;
  localparam logic [7:0] ADDR_HPF       = 8'h38;
  localparam logic [7:0] ADDR_STRIDE    = 8'h02;

  // reset values
  localparam logic [7:0] RESET_HIGH = 8'h00;
  localparam logic [7:0] RESET_LOW  = 8'h00;
  localparam logic [7:0] RESET_HPF  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // writable bits; reserved bits read as zero
  localparam logic [7:0] WMASK_X_LOW  = 8'he3;
  localparam logic [7:0] WMASK_YZ_LOW = 8'he1;
  localparam logic [7:0] WMASK_HPF    = 8'h03;

  // field positions
  localparam int LOW_LEVEL_MSB = 7;
  localparam int LOW_LEVEL_LSB = 5;
  localparam int REF_SEL_BIT   = 1;
  localparam int ENABLE_BIT    = 0;
  localparam int CORNER_MSB    = 1;
  localparam int CORNER_LSB    = 0;

  // data widths
  localparam int NUM_AXES = 3;
  localparam int SAMPLE_W = 12;
  localparam int LEVEL_W  = 11;
  localparam int MAG_W    = 12;
  localparam int HP_W     = 13;
  localparam int FRAC_W   = 8;
  localparam int ACC_W    = SAMPLE_W + FRAC_W + 1;

  // scale of a threshold code and of a sample, milli-g per code
  localparam int MILLI_G_PER_CODE = 100;

  // corner figures in centi-hertz at 5120 Hz and 2560 Hz output rate
  localparam int CORNER0_CHZ_5120 = 3048;
  localparam int CORNER0_CHZ_2560 = 1524;
  localparam int CORNER1_CHZ_5120 = 1558;
  localparam int CORNER1_CHZ_2560 = 779;
  localparam int CORNER2_CHZ_5120 = 788;
  localparam int CORNER2_CHZ_2560 = 394;
  localparam int CORNER3_CHZ_5120 = 396;
  localparam int CORNER3_CHZ_2560 = 198;
  // one-pole leaky integrator: corner is about rate / (2 pi 2^shift), so the
  // corner tracks the sample rate and each code step halves it
  localparam int HPF_BASE_SHIFT = 5;

  // reference capture state
  typedef enum logic [1:0] {
    REF_WAIT = 2'b01,
    REF_HELD = 2'b10
  } mwt_ref_t;
endpackage

// file: design/mwt_regs.sv
// motion-warning threshold registers, detector and high-pass corner select
`timescale 1ns/1ns
`default_nettype none
module mwt_regs (
  input  wire logic                                clk,         // 125 MHz clock
  input  wire logic                                rst_n,       // sync reset, active low
  input  wire logic        [7:0]                   regAddr,     // register address
  input  wire logic        [7:0]                   regWrData,   // write data
  input  wire logic                                regWrEn,     // write strobe
  input  wire logic                                regRdEn,     // read strobe
  output logic             [7:0]                   regRdData,   // read data
  output logic                                     regRdValid,  // read data valid pulse
  input  wire logic                                sampleValid, // new sample pulse
  input  wire logic signed [mwt_pkg::SAMPLE_W-1:0] sampleX,     // x sample
  input  wire logic signed [mwt_pkg::SAMPLE_W-1:0] sampleY,     // y sample
  input  wire logic signed [mwt_pkg::SAMPLE_W-1:0] sampleZ,     // z sample
  output logic                                     motionWarn,  // over threshold pulse
  output logic             [2:0]                   overAxes,    // axes over at last event
  output logic signed [mwt_pkg::HP_W-1:0]          hpOutX,      // high-passed x
  output logic signed [mwt_pkg::HP_W-1:0]          hpOutY,      // high-passed y
  output logic signed [mwt_pkg::HP_W-1:0]          hpOutZ,      // high-passed z
  output logic                                     hpValid      // high-passed data pulse
);
  localparam int NA = mwt_pkg::NUM_AXES;

  logic        [7:0]                   highR [NA];
  logic        [7:0]                   lowR  [NA];
  logic        [1:0]                   cornerR;
  logic signed [mwt_pkg::SAMPLE_W-1:0] sampleIn [NA];
  logic signed [mwt_pkg::SAMPLE_W-1:0] refR [NA];
  logic signed [mwt_pkg::HP_W-1:0]     hpR  [NA];
  logic        [NA-1:0]                overNow;
  logic        [NA-1:0]                lowWrite;
  logic        [mwt_pkg::LEVEL_W-1:0]  level [NA];
  logic        [NA-1:0]                axisEn;
  logic                                refSel;
  logic        [3:0]                   hpShift;
  mwt_pkg::mwt_ref_t                   refState_r;
  mwt_pkg::mwt_ref_t                   refState_nxt;

  assign sampleIn[0] = sampleX;
  assign sampleIn[1] = sampleY;
  assign sampleIn[2] = sampleZ;
  assign refSel  = lowR[0][mwt_pkg::REF_SEL_BIT];
  // wider corner code means a longer integrator and a lower corner
  assign hpShift = 4'(mwt_pkg::HPF_BASE_SHIFT) + {2'b00, cornerR};

  // per-axis registers, filter and comparator
  for (genvar a = 0; a < NA; a++) begin : g_axis
    localparam logic [7:0] HIGH_ADDR = mwt_pkg::ADDR_AXIS_BASE + 8'(a) * mwt_pkg::ADDR_STRIDE;
    localparam logic [7:0] LOW_ADDR  = HIGH_ADDR + 8'h01;
    localparam logic [7:0] LOW_MASK  = (a == 0) ? mwt_pkg::WMASK_X_LOW : mwt_pkg::WMASK_YZ_LOW;

    logic signed [mwt_pkg::ACC_W-1:0] accR;
    logic signed [mwt_pkg::ACC_W-1:0] accErr;
    logic signed [mwt_pkg::HP_W-1:0]  hpNxt;

    assign lowWrite[a] = regWrEn && (regAddr == LOW_ADDR);
    // high byte holds level bits 10:3, low byte bits 7:5 hold 2:0
    assign level[a]  = {highR[a], lowR[a][mwt_pkg::LOW_LEVEL_MSB:mwt_pkg::LOW_LEVEL_LSB]};
    assign axisEn[a] = lowR[a][mwt_pkg::ENABLE_BIT];

    // threshold byte writes; reserved low bits are never stored
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        highR[a] <= mwt_pkg::RESET_HIGH;
        lowR[a]  <= mwt_pkg::RESET_LOW;
      end else if (regWrEn) begin
        if (regAddr == HIGH_ADDR) begin
          highR[a] <= regWrData;
        end else if (regAddr == LOW_ADDR) begin
          lowR[a] <= regWrData & LOW_MASK;
        end
      end
    end

    // leaky integrator tracks the slow part; output is sample minus it
    assign accErr = ($signed({sampleIn[a], {mwt_pkg::FRAC_W{1'b0}}}) - accR) >>> hpShift;
    assign hpNxt  = mwt_pkg::HP_W'(sampleIn[a]) -
                    mwt_pkg::HP_W'(accR >>> mwt_pkg::FRAC_W);

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        accR   <= '0;
        hpR[a] <= '0;
      end else if (sampleValid) begin
        accR   <= accR + accErr;
        hpR[a] <= hpNxt;
      end
    end

    // reference follows the first sample after re-arming
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        refR[a] <= '0;
      end else if (sampleValid && refState_r == mwt_pkg::REF_WAIT) begin
        refR[a] <= sampleIn[a];
      end
    end

    // threshold and samples share the 100 mg code, so no rescaling here
    mwt_axis_cmp u_cmp (
      .sample    (sampleIn[a]),
      .refSample (refR[a]),
      .useRef    (refSel),
      .level     (level[a]),
      .enable    (axisEn[a]),
      .over      (overNow[a])
    );
  end

  // corner select write; upper bits reserved
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cornerR <= mwt_pkg::RESET_HPF[mwt_pkg::CORNER_MSB:mwt_pkg::CORNER_LSB];
    end else if (regWrEn && regAddr == mwt_pkg::ADDR_HPF) begin
      cornerR <= regWrData[mwt_pkg::CORNER_MSB:mwt_pkg::CORNER_LSB];
    end
  end

  // any low-register write may change enables or mode, so re-take reference
  always_comb begin
    refState_nxt = refState_r;
    case (refState_r)
      mwt_pkg::REF_WAIT: begin
        if (sampleValid) begin
          refState_nxt = mwt_pkg::REF_HELD;
        end
      end
      mwt_pkg::REF_HELD: begin
        refState_nxt = mwt_pkg::REF_HELD;
      end
      default: begin
        refState_nxt = mwt_pkg::REF_WAIT;
      end
    endcase
    if (|lowWrite) begin
      refState_nxt = mwt_pkg::REF_WAIT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refState_r <= mwt_pkg::REF_WAIT;
    end else begin
      refState_r <= refState_nxt;
    end
  end

  // event pulse; in referenced mode the capturing sample itself cannot fire
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motionWarn <= 1'b0;
      overAxes   <= 3'h0;
    end else if (sampleValid && (!refSel || refState_r == mwt_pkg::REF_HELD)) begin
      motionWarn <= |overNow;
      if (|overNow) begin
        overAxes <= overNow;
      end
    end else begin
      motionWarn <= 1'b0;
    end
  end

  // filtered data valid one cycle after the sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hpValid <= 1'b0;
    end else begin
      hpValid <= sampleValid;
    end
  end

  assign hpOutX = hpR[0];
  assign hpOutY = hpR[1];
  assign hpOutZ = hpR[2];

  // read port: registered data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData  <= mwt_pkg::READ_UNMAPPED;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        if (regAddr == mwt_pkg::ADDR_X_HIGH) begin
          regRdData <= highR[0];
        end else if (regAddr == mwt_pkg::ADDR_X_LOW) begin
          regRdData <= lowR[0];
        end else if (regAddr == mwt_pkg::ADDR_Y_HIGH) begin
          regRdData <= highR[1];
        end else if (regAddr == mwt_pkg::ADDR_Y_LOW) begin
          regRdData <= lowR[1];
        end else if (regAddr == mwt_pkg::ADDR_Z_HIGH) begin
          regRdData <= highR[2];
        end else if (regAddr == mwt_pkg::ADDR_Z_LOW) begin
          regRdData <= lowR[2];
        end else if (regAddr == mwt_pkg::ADDR_HPF) begin
          regRdData <= {6'h00, cornerR};
        end else begin
          regRdData <= mwt_pkg::READ_UNMAPPED;
        end
      end
    end
  end
endmodule // mwt_regs
`default_nettype wire

// file: sim/mwt_host_model.sv
// host processor model driving the decoded register bus
`timescale 1ns/1ns
`default_nettype none
module mwt_host_model (
  input  wire logic       clk,        // clock
  output var  logic [7:0] regAddr,    // address
  output var  logic [7:0] regWrData,  // write data
  output var  logic       regWrEn,    // write strobe
  output var  logic       regRdEn,    // read strobe
  input  wire logic [7:0] regRdData,  // read data
  input  wire logic       regRdValid  // read valid
);
  // idle bus at time zero
  initial {regAddr, regWrData, regWrEn, regRdEn} = 18'h0;
  // one access; released lines invert so stale values are never trusted
  task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic v);
    @(negedge clk);
    {regAddr, regWrData, regWrEn, regRdEn} = {a, d, we, !we};
    @(negedge clk);
    {regAddr, regWrData, regWrEn, regRdEn} = {~a, ~d, 2'b00};
    q = regRdData;
    v = regRdValid;
  endtask
endmodule // mwt_host_model
`default_nettype wire

// file: sim/mwt_regs_asserts.sv
// assertion checker for the motion-warning register block
`timescale 1ns/1ns
`default_nettype none
module mwt_regs_chk (
  input wire logic       clk,         // clock
  input wire logic       rst_n,       // sync reset
  input wire logic [7:0] regAddr,     // address
  input wire logic [7:0] regWrData,   // write data
  input wire logic       regWrEn,     // write strobe
  input wire logic       regRdEn,     // read strobe
  input wire logic [7:0] regRdData,   // read data
  input wire logic       regRdValid,  // read valid
  input wire logic       sampleValid, // sample strobe
  input wire logic       motionWarn,  // event pulse
  input wire logic [2:0] overAxes,    // axes over
  input wire logic       hpValid      // filter valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write of the y high byte, an idle cycle, then its read back
  sequence s_wr; regWrEn && regAddr == 8'h34; endsequence
  sequence s_rd; regRdEn && !regWrEn && regAddr == 8'h34; endsequence
  AST_RD_ANSWER: assert property (regRdEn |=> regRdValid)
    else $error("read gave no valid");
  AST_X_LOW_RSV: assert property (
    regRdEn && regAddr == 8'h33 |=> regRdData[4:2] == 3'h0) else $error("x low reserved set");
  AST_YZ_LOW_RSV: assert property (
    regRdEn && (regAddr == 8'h35 || regAddr == 8'h37) |=> regRdData[4:1] == 4'h0)
    else $error("yz low reserved set");
  AST_HPF_RSV: assert property (
    regRdEn && regAddr == 8'h38 |=> regRdData[7:2] == 6'h00) else $error("hpf reserved set");
  AST_UNMAPPED: assert property (
    regRdEn && (regAddr < 8'h32 || regAddr > 8'h38) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_WR_BACK: assert property (
    s_wr ##1 !regWrEn ##1 s_rd |=> regRdData == $past(regWrData, 3))
    else $error("y high read back differs");
  AST_HP_VALID: assert property (sampleValid |=> hpValid)
    else $error("no filter output");
  AST_WARN_CAUSE: assert property (motionWarn |-> $past(sampleValid))
    else $error("event without sample");
  AST_WARN_AXES: assert property (motionWarn |-> overAxes != 3'h0)
    else $error("event with no axis");
endmodule // mwt_regs_chk
bind mwt_regs mwt_regs_chk i_mwt_regs_chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .regRdValid(regRdValid), .sampleValid(sampleValid), .motionWarn(motionWarn),
  .overAxes(overAxes), .hpValid(hpValid));
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the motion-warning register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               sampleValid = 1'b0;
  logic signed [11:0] sampleX = 12'sd0, sampleY = 12'sd0, sampleZ = 12'sd0;
  logic        [7:0]  regAddr, regWrData, regRdData;
  logic               regWrEn, regRdEn, regRdValid, motionWarn, hpValid;
  logic        [2:0]  overAxes;
  logic signed [12:0] hpOutX, hpOutY, hpOutZ;
  int                 error_cnt = 0, tests_run = 0;
  always #4 clk = ~clk;
  mwt_regs i_mwt_regs (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .sampleValid(sampleValid), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
    .motionWarn(motionWarn), .overAxes(overAxes), .hpOutX(hpOutX), .hpOutY(hpOutY),
    .hpOutZ(hpOutZ), .hpValid(hpValid));
  mwt_host_model i_mwt_host_model (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    i_mwt_host_model.acc(1'b1, a, d, q, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       v;
    i_mwt_host_model.acc(1'b0, a, 8'h00, q, v);
    chk("rdValid", 16'h1, 16'(v));
    chk("rdData", 16'(e), 16'(q));
  endtask
  // one sample; lines invert afterwards so a late capture shows up
  task automatic samp(input logic signed [11:0] x, y, z, input logic w, input logic [2:0] ax);
    @(negedge clk);
    {sampleValid, sampleX, sampleY, sampleZ} = {1'b1, x, y, z};
    @(negedge clk);
    {sampleValid, sampleX, sampleY, sampleZ} = {1'b0, ~x, ~y, ~z};
    chk("hpValid", 16'h1, 16'(hpValid));
    chk("motionWarn", 16'(w), 16'(motionWarn));
    if (w) chk("overAxes", 16'(ax), 16'(overAxes));
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
  endtask
  // filter starts from zero, so the second output shows the decay step of each code
  task automatic t_hpf();
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr(8'h38, 8'(c));
      rd(8'h38, 8'(c));
      samp(12'sd1024, -12'sd1024, 12'sd512, 1'b0, 3'h0);
      samp(12'sd1024, -12'sd1024, 12'sd512, 1'b0, 3'h0);
      chk("hpOutX", 16'(1024 - (32 >> c)), 16'(hpOutX));
      chk("hpOutY", 16'((32 >> c) - 1024), 16'(hpOutY));
      chk("hpOutZ", 16'(512 - (16 >> c)), 16'(hpOutZ));
    end
    $display("test hpf done");
  endtask
  // first sample after arming is the reference and never warns
  task automatic t_ref();
    do_reset();
    wr(8'h33, 8'h23);
    samp(12'sd500, 12'sd0, 12'sd0, 1'b0, 3'h0);
    samp(12'sd500, 12'sd0, 12'sd0, 1'b0, 3'h0);
    samp(12'sd503, 12'sd0, 12'sd0, 1'b1, 3'h1);
    $display("test ref done");
  endtask
  task automatic t_regs();
    logic [7:0] m [7] = '{8'hff, 8'he3, 8'hff, 8'he1, 8'hff, 8'he1, 8'h03};
    do_reset();
    for (int i = 0; i < 7; i++) rd(8'h32 + 8'(i), 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'h32 + 8'(i), 8'hff);
      rd(8'h32 + 8'(i), m[i]);
    end
    wr(8'h39, 8'hff);
    rd(8'h39, 8'h00);
    rd(8'h31, 8'h00);
    $display("test regs done");
  endtask
  // x level 133, y level 1, z level 2040; strict greater on magnitude
  task automatic t_detect();
    wr(8'h32, 8'h10);
    wr(8'h33, 8'ha1);
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h21);
    wr(8'h37, 8'h00);
    samp(12'sd133, 12'sd1, -12'sd2047, 1'b0, 3'h0);
    samp(-12'sd134, 12'sd0, 12'sd0, 1'b1, 3'h1);
    samp(12'sd0, -12'sd2, 12'sd0, 1'b1, 3'h2);
    wr(8'h37, 8'h01);
    samp(12'sd0, 12'sd0, -12'sd2040, 1'b0, 3'h0);
    samp(12'sd0, 12'sd0, -12'sd2041, 1'b1, 3'h4);
    $display("test detect done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    t_hpf();
    t_ref();
    t_regs();
    t_detect();
    wrap_up();
  end
  // watchdog: tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
